// file: verilog/ssb_step_sequencer_bank.sv
// Purpose: eight step sequencers sharing counters 1..8 plus a 64-entry
//          counter present value array
// Assumes: command conditions come from same-clock scan logic and are
//          sampled on scan_tick_in
// Notes:   counters 9..64 are plain storage; only 1..8 drive sequencers
// Summary of operation
// - eight independent sequencers, each decoding up to 32 steps
// - sequencer k shares the present value of counter k
// - the counter limit value is the highest step before wrapping
// - a rising advance on an inactive sequencer makes it active at step 1
// - each later rising advance adds one, exactly like count up
// - advancing at the limit wraps the step to 0
// - wrapping raises the done flag until the next increment or deactivate
// - one decoded bit per sequencer and step 0..31, high while active there
// - deactivate makes the sequencer inactive at any time
// - an inactive sequencer shows no decoded bits, not even step 0
// - load step sets the given step regardless of state
// - count down subtracts one from the step; from step 0 it wraps to the limit
// - a software write to the present value sets the step at once
// - all 64 present values are readable and writable by software
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module ssb_step_sequencer_bank (
  // clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    arst_n_in,
  // register port
  input  wire logic [7:0]              reg_addr_in,
  input  wire logic [15:0]             reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic      [15:0]             reg_rdata_out,
  // scan commands, one bit per sequencer
  input  wire logic                    scan_tick_in,
  input  wire logic [7:0]              advance_step_cmd_in,
  input  wire logic [7:0]              count_up_cmd_in,
  input  wire logic [7:0]              count_down_cmd_in,
  input  wire logic [7:0]              deactivate_cmd_in,
  input  wire logic [7:0]              load_step_cmd_in,
  input  wire logic [15:0]             load_step_value_in,
  // sequencer state
  output logic      [7:0]              seq_active_out,
  output logic      [7:0]              seq_done_out,
  output logic      [7:0][31:0]        step_decode_bit_out
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [63:0][15:0] pv;
    logic [7:0][15:0]  lim;
    logic [7:0]        act;
    logic [7:0]        done;
    logic [7:0]        adv_p;
    logic [7:0]        up_p;
    logic [7:0]        dn_p;
    logic [7:0]        ld_p;
    logic [7:0][31:0]  dec;
    logic [15:0]       rd;
  } ssb_state_s;

  ssb_state_s s_q;
  ssb_state_s s_d;

  // ==========================================================
  // helpers
  // next step going up; at or past the limit it wraps to 0
  function automatic logic [15:0] ssb_step_up(input logic [15:0] v,
                                              input logic [15:0] lim);
    ssb_step_up = (v >= lim) ? 16'h0000 : 16'(v + 16'h0001);
  endfunction : ssb_step_up

  // one-hot step bits; steps above 31 have no bit
  // a limit above 31 still counts, but those steps light no bit
  function automatic logic [31:0] ssb_decode(input logic a,
                                             input logic [15:0] v);
    ssb_decode = (a && v < 16'(ssb_pkg::STEP_BITS)) ? (32'h0000_0001 << v[4:0])
                                                     : 32'h0000_0000;
  endfunction : ssb_decode

  // counter present value window: the low 64 word addresses
  function automatic logic ssb_is_pv(input logic [7:0] a);
    ssb_is_pv = (a[7:6] == ssb_pkg::ADDR_PV_BASE[7:6]);
  endfunction : ssb_is_pv

  // limit window: eight words from the limit base
  function automatic logic ssb_is_lim(input logic [7:0] a);
    ssb_is_lim = (a[7:3] == ssb_pkg::ADDR_LIM_BASE[7:3]);
  endfunction : ssb_is_lim

  // next step going down; below step 0 it wraps to the limit
  function automatic logic [15:0] ssb_step_down(input logic [15:0] v,
                                                input logic [15:0] lim);
    ssb_step_down = (v == 16'h0000) ? lim : 16'(v - 16'h0001);
  endfunction : ssb_step_down

  // ==========================================================
  // next state
  // scan commands beat a software write in the same cycle, so a
  // scan never sees a half-applied value
  always_comb
  begin
    logic [7:0] adv_r;
    logic [7:0] dn_r;
    logic [7:0] ld_r;
    adv_r = 8'h00;
    dn_r  = 8'h00;
    ld_r  = 8'h00;
    s_d    = s_q;
    s_d.rd = 16'h0000;
    // register read: answer lands one cycle later
    if (reg_rd_in)
    begin
      if (ssb_is_pv(reg_addr_in))
        s_d.rd = s_q.pv[reg_addr_in[5:0]];
      else if (ssb_is_lim(reg_addr_in))
        s_d.rd = s_q.lim[reg_addr_in[2:0]];
      else if (reg_addr_in == ssb_pkg::ADDR_STATUS)
      begin
        s_d.rd[ssb_pkg::ST_ACT_LSB +: 8]  = s_q.act;
        s_d.rd[ssb_pkg::ST_DONE_LSB +: 8] = s_q.done;
      end
    end
    // register write; unmapped addresses are ignored
    if (reg_wr_in)
    begin
      if (ssb_is_pv(reg_addr_in))
      begin
        s_d.pv[reg_addr_in[5:0]] = reg_wdata_in;
        // writing counters 1..8 also wakes the matching sequencer
        if (reg_addr_in[5:3] == 3'b000)
          s_d.act[reg_addr_in[2:0]] = 1'b1;
      end
      else if (ssb_is_lim(reg_addr_in))
        s_d.lim[reg_addr_in[2:0]] = reg_wdata_in;
    end
    // scan: edges against last scan, highest priority first
    // the level history only moves on a tick, so idle cycles never fake an edge
    if (scan_tick_in)
    begin
      adv_r = (advance_step_cmd_in & ~s_q.adv_p)
            | (count_up_cmd_in & ~s_q.up_p);
      dn_r  = count_down_cmd_in & ~s_q.dn_p;
      ld_r  = load_step_cmd_in & ~s_q.ld_p;
      for (int i = 0; i < ssb_pkg::NUM_SEQ; i++)
      begin
        // deactivate is a level: it keeps the sequencer idle on every scan it stays on
        if (deactivate_cmd_in[i])
        begin
          s_d.act[i]  = 1'b0;
          s_d.done[i] = 1'b0;
        end
        else if (ld_r[i])
        begin
          s_d.pv[i]  = load_step_value_in;
          s_d.act[i] = 1'b1;
        end
        else if (adv_r[i])
        begin
          if (!s_q.act[i])
          begin
            s_d.act[i]  = 1'b1;
            s_d.pv[i]   = 16'h0001;
            s_d.done[i] = 1'b0;
          end
          else
          begin
            s_d.pv[i]   = ssb_step_up(s_q.pv[i], s_q.lim[i]);
            s_d.done[i] = (s_q.pv[i] >= s_q.lim[i]);
          end
        end
        // down leaves active and done alone; only an increment or deactivate clears done
        else if (dn_r[i])
        begin
          s_d.pv[i] = ssb_step_down(s_q.pv[i], s_q.lim[i]);
        end
      end
      s_d.adv_p = advance_step_cmd_in;
      s_d.up_p  = count_up_cmd_in;
      s_d.dn_p  = count_down_cmd_in;
      s_d.ld_p  = load_step_cmd_in;
    end
    // step bits follow the new state so they stand from a flip-flop
    for (int j = 0; j < ssb_pkg::NUM_SEQ; j++)
      s_d.dec[j] = ssb_decode(s_d.act[j], s_d.pv[j]);
  end

  // ==========================================================
  // state register
  // limits come back at 31 so a fresh bank never runs past its step bits
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_q       <= '0;
      s_q.pv    <= {64{ssb_pkg::PV_RST}};
      s_q.lim   <= {8{ssb_pkg::LIM_RST}};
    end
    else
      s_q <= s_d;
  end

  // ==========================================================
  // outputs
  // every output is a register copy; nothing here is combinational
  assign reg_rdata_out       = s_q.rd;
  assign seq_active_out      = s_q.act;
  assign seq_done_out        = s_q.done;
  assign step_decode_bit_out = s_q.dec;

  // ==========================================================
  // checks on sequencer 1
  // only sequencer 1 is watched; the loop makes the others identical,
  // and watching all eight would multiply the checks for little gain
  // isolated edge terms so the checks read plainly
  logic adv0_r;
  logic dn0_r;
  logic ld0_r;
  logic pv0_wr;
  assign adv0_r = scan_tick_in & ((advance_step_cmd_in[0] & ~s_q.adv_p[0])
                                | (count_up_cmd_in[0] & ~s_q.up_p[0]));
  assign dn0_r  = scan_tick_in & count_down_cmd_in[0] & ~s_q.dn_p[0];
  assign ld0_r  = scan_tick_in & load_step_cmd_in[0] & ~s_q.ld_p[0];
  assign pv0_wr = reg_wr_in & (reg_addr_in == ssb_pkg::ADDR_PV_BASE);

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  property p_start;
    adv0_r && !s_q.act[0] && !deactivate_cmd_in[0] && !ld0_r
      |=> s_q.act[0] && s_q.pv[0] == 16'h0001 && s_q.dec[0] == 32'h0000_0002;
  endproperty
  a_start: assert property (p_start) else $error("start not at step 1");

  property p_inc;
    adv0_r && s_q.act[0] && s_q.pv[0] < s_q.lim[0]
      && !deactivate_cmd_in[0] && !ld0_r
      |=> s_q.pv[0] == 16'($past(s_q.pv[0]) + 16'h0001) && !s_q.done[0];
  endproperty
  a_inc: assert property (p_inc) else $error("advance did not add one");

  property p_wrap;
    adv0_r && s_q.act[0] && s_q.pv[0] == s_q.lim[0]
      && !deactivate_cmd_in[0] && !ld0_r
      |=> s_q.pv[0] == 16'h0000 && s_q.done[0];
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap to step 0");

  property p_done_hold;
    s_q.done[0] && !adv0_r && !(scan_tick_in && deactivate_cmd_in[0])
      |=> s_q.done[0];
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done dropped");

  property p_decode;
    s_q.act[0] && s_q.pv[0] < 16'(ssb_pkg::STEP_BITS)
      |-> s_q.dec[0] == (32'h0000_0001 << s_q.pv[0][4:0]);
  endproperty
  a_decode: assert property (p_decode) else $error("bad step bit");

  property p_deact;
    scan_tick_in && deactivate_cmd_in[0]
      |=> !s_q.act[0] && s_q.dec[0] == 32'h0000_0000;
  endproperty
  a_deact: assert property (p_deact) else $error("still active");

  property p_deact_done;
    scan_tick_in && deactivate_cmd_in[0] |=> !s_q.done[0];
  endproperty
  a_deact_done: assert property (p_deact_done) else $error("done kept when idle");

  property p_inact;
    !s_q.act[0] |-> s_q.dec[0] == 32'h0000_0000;
  endproperty
  a_inact: assert property (p_inact) else $error("inactive shows a step");

  property p_high_step;
    s_q.pv[0] >= 16'(ssb_pkg::STEP_BITS) |-> s_q.dec[0] == 32'h0000_0000;
  endproperty
  a_high_step: assert property (p_high_step) else $error("step above 31 decoded");

  property p_load;
    ld0_r && !deactivate_cmd_in[0]
      |=> s_q.act[0] && s_q.pv[0] == $past(load_step_value_in);
  endproperty
  a_load: assert property (p_load) else $error("load step lost");

  property p_down;
    dn0_r && !adv0_r && !ld0_r && !deactivate_cmd_in[0]
      |=> s_q.pv[0] == (($past(s_q.pv[0]) == 16'h0000) ? $past(s_q.lim[0])
                        : 16'($past(s_q.pv[0]) - 16'h0001));
  endproperty
  a_down: assert property (p_down) else $error("down count wrong");

  property p_dn_act;
    dn0_r && !adv0_r && !ld0_r && !deactivate_cmd_in[0] && !pv0_wr
      |=> $stable(s_q.act[0]) && $stable(s_q.done[0]);
  endproperty
  a_dn_act: assert property (p_dn_act) else $error("down count changed flags");

  property p_write;
    pv0_wr && !scan_tick_in |=> s_q.pv[0] == $past(reg_wdata_in) && s_q.act[0];
  endproperty
  a_write: assert property (p_write) else $error("write not applied");

  property p_lim_wr;
    reg_wr_in && reg_addr_in == ssb_pkg::ADDR_LIM_BASE
      |=> s_q.lim[0] == $past(reg_wdata_in);
  endproperty
  a_lim_wr: assert property (p_lim_wr) else $error("limit write lost");

  property p_quiet;
    !scan_tick_in && !pv0_wr |=> $stable(s_q.pv[0]);
  endproperty
  a_quiet: assert property (p_quiet) else $error("step moved off scan");

  property p_scan_hold;
    scan_tick_in && !adv0_r && !dn0_r && !ld0_r && !pv0_wr
      |=> $stable(s_q.pv[0]);
  endproperty
  a_scan_hold: assert property (p_scan_hold) else $error("step moved without an edge");

  property p_read;
    reg_rd_in && ssb_is_pv(reg_addr_in) && !reg_wr_in
      |=> reg_rdata_out == $past(s_q.pv[reg_addr_in[5:0]]);
  endproperty
  a_read: assert property (p_read) else $error("read data wrong");

  property p_rd_idle;
    !reg_rd_in |=> reg_rdata_out == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");

  property p_status_rd;
    reg_rd_in && reg_addr_in == ssb_pkg::ADDR_STATUS && !reg_wr_in
      |=> reg_rdata_out[ssb_pkg::ST_ACT_LSB +: 8] == $past(s_q.act)
       && reg_rdata_out[ssb_pkg::ST_DONE_LSB +: 8] == $past(s_q.done);
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status read wrong");

endmodule : ssb_step_sequencer_bank

// file: verilog/ssb_pkg.sv
// Purpose: shared constants for the step sequencer bank
// Assumes: 16-bit counter present values, word-indexed register port
// Notes:   counter k (1..64) sits at index k-1; sequencers use 1..8
package ssb_pkg;
  // ==========================================================
  // sizes
  localparam int NUM_SEQ   = 8;
  localparam int NUM_CTR   = 64;
  localparam int STEP_BITS = 32;
  // ==========================================================
  // register map (word addresses)
  localparam logic [7:0] ADDR_PV_BASE  = 8'h00;  // 64 present values
  localparam logic [7:0] ADDR_LIM_BASE = 8'h40;  // 8 limit values
  localparam logic [7:0] ADDR_STATUS   = 8'h48;  // active and done flags
  // ==========================================================
  // status field positions
  localparam int ST_ACT_LSB  = 0;
  localparam int ST_DONE_LSB = 8;
  // ==========================================================
  // reset values
  localparam logic [15:0] PV_RST  = 16'h0000;
  localparam logic [15:0] LIM_RST = 16'h001F;
endpackage : ssb_pkg

// file: bench/ssb_scan_model.sv
// Purpose: program scan model that feeds command levels to the sequencer bank
// Assumes: the bench asks for one scan at a time through go_in
// Notes:   levels change only together with a scan tick, like a real scan
`timescale 1ns/1ps
module ssb_scan_model (
  // clock and reset
  input  wire logic            clock_in,
  input  wire logic            arst_n_in,
  // requests from the bench
  input  wire logic            go_in,
  input  wire logic [4:0][7:0] cmd_in,
  input  wire logic [15:0]     val_in,
  // scan side toward the block
  output logic                 scan_tick_out,
  output logic      [4:0][7:0] cmd_out,
  output logic      [15:0]     val_out
);
  // ==========================================================
  // scan register
  // conditions are held between ticks so each scan sees a stable set
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      scan_tick_out <= 1'b0;
      cmd_out       <= '0;
      val_out       <= 16'h0000;
    end
    else
    begin
      scan_tick_out <= go_in;
      if (go_in)
      begin
        cmd_out <= cmd_in;
        val_out <= val_in;
      end
    end
  end
endmodule : ssb_scan_model

// file: bench/testbench.sv
// Purpose: self-checking bench for the step sequencer bank
// Assumes: one scan per scan call; commands are levels
// Notes:   expected steps live in a small shadow model (ea, es)
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // signals
  logic             clock_in;
  logic             arst_n_in;
  logic [7:0]       reg_addr_in;
  logic [15:0]      reg_wdata_in;
  logic             reg_wr_in;
  logic             reg_rd_in;
  logic [15:0]      reg_rdata_out;
  logic             go;
  logic [4:0][7:0]  cmd;  // 0 advance, 1 up, 2 down, 3 deactivate, 4 load
  logic [4:0][7:0]  cmd_q;
  logic [15:0]      val;
  logic [15:0]      val_q;
  logic             tick;
  logic [7:0]       act_out;
  logic [7:0]       done_out;
  logic [7:0][31:0] dec_out;
  int               errors;
  int               total_checks;
  logic [7:0]       ea;
  int               es [8];

  // ==========================================================
  // instances
  ssb_scan_model scan_model (.clock_in(clock_in), .arst_n_in(arst_n_in), .go_in(go),
    .cmd_in(cmd), .val_in(val), .scan_tick_out(tick), .cmd_out(cmd_q), .val_out(val_q));
  ssb_step_sequencer_bank dut (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .scan_tick_in(tick),
    .advance_step_cmd_in(cmd_q[0]), .count_up_cmd_in(cmd_q[1]),
    .count_down_cmd_in(cmd_q[2]), .deactivate_cmd_in(cmd_q[3]),
    .load_step_cmd_in(cmd_q[4]), .load_step_value_in(val_q),
    .seq_active_out(act_out), .seq_done_out(done_out), .step_decode_bit_out(dec_out));

  // ==========================================================
  // clock and watchdog
  always #2 clock_in = ~clock_in;
  // a hang counts as a mismatch and still reaches the verdict
  initial
  begin
    repeat (5000) @(posedge clock_in);
    errors++;
    conclude();
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // all eight sequencers at once, so a stray change anywhere shows up
  task automatic verify();
    logic [31:0] e;
    for (int k = 0; k < 8; k++)
    begin
      e = (ea[k] && es[k] < 32) ? 32'h0000_0001 << es[k] : 32'h0000_0000;
      chk(act_out[k], ea[k], "active");
      chk(dec_out[k], e, "decode");
    end
  endtask : verify
  task automatic scan(input int c, input logic [7:0] m);
    logic [4:0][7:0] n;
    n = '0;
    n[c] = m;
    @(posedge clock_in);
    cmd <= n;
    go  <= 1'b1;
    @(posedge clock_in);
    go  <= 1'b0;
    @(posedge clock_in);
    #1;
  endtask : scan
  // a released scan first, so the next one is a clean rising edge
  task automatic rise(input int c, input logic [7:0] m);
    scan(c, 8'h00);
    scan(c, m);
  endtask : rise
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clock_in);
    reg_wr_in    <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string what);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clock_in);
    reg_rd_in   <= 1'b0;
    #1;
    chk(reg_rdata_out, e, what);
  endtask : rd
  task automatic conclude();
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(8'h48, 16'h0000, "status");
    rd(8'h40, 16'h001F, "limit");
    rd(8'h07, 16'h0000, "pv");
    verify();
  endtask : t_reset
  task automatic t_advance();
    wr(8'h40, 16'h0003);
    rise(0, 8'h01);
    ea[0] = 1'b1;
    es[0] = 1;
    verify();
    scan(0, 8'h01);
    verify();
    rise(1, 8'h01);
    es[0] = 2;
    verify();
    rise(0, 8'h01);
    rise(0, 8'h01);
    es[0] = 0;
    verify();
    chk(done_out, 8'h01, "done");
    rise(0, 8'h01);
    es[0] = 1;
    chk(done_out, 8'h00, "done");
    rd(8'h00, 16'h0001, "pv");
  endtask : t_advance
  task automatic t_down();
    rise(2, 8'h01);
    es[0] = 0;
    verify();
    rise(2, 8'h01);
    es[0] = 3;
    verify();
  endtask : t_down
  task automatic t_deact_load();
    scan(3, 8'h01);
    ea[0] = 1'b0;
    verify();
    rise(4, 8'h81);
    ea = 8'h81;
    es[0] = 0;
    es[7] = 0;
    verify();
    @(posedge clock_in);
    val <= 16'h0014;
    rise(4, 8'h80);
    es[7] = 20;
    verify();
  endtask : t_deact_load
  task automatic t_write();
    wr(8'h02, 16'h000A);
    ea[2] = 1'b1;
    es[2] = 10;
    verify();
    rd(8'h02, 16'h000A, "pv");
    wr(8'h27, 16'h1234);
    rd(8'h27, 16'h1234, "pv");
    wr(8'h00, 16'h0025);
    es[0] = 37;
    verify();
    rd(8'h50, 16'h0000, "unmapped");
    rd(8'h48, {8'h00, ea}, "status");
  endtask : t_write

  // ==========================================================
  // main sequence
  initial
  begin
    clock_in = 1'b0;
    arst_n_in = 1'b0;
    {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in, go, cmd, val} = '0;
    {errors, total_checks} = '0;
    ea = 8'h00;
    es = '{default: 0};
    repeat (6) @(posedge clock_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_advance();
    t_down();
    t_deact_load();
    t_write();
    conclude();
  end
endmodule : testbench
